/* logic/adcr_pkg.sv */
// constants and types of the converter status, test and port registers
//
// Overview of operation
// - enable bit set turns the select code into a special code.
// - special codes 100 high, 101 low, 110 midpoint; others reserved.
// - test bits seven and six read undefined; writes accepted anytime.
// - flag x sets when conversion x of a sequence completes.
// - any write to conversion start control clears all eight flags.
// - without fast clear, flag x clears on status read then result read.
// - with fast clear, any read of result x clears flag x.
// - status and port data registers read anytime; writes change nothing.
// - input enable bit x gates pin x buffer; register read/write anytime.
// - enabled bit x reads the current level on analog pin x.
// - disabled bit x reads constant one whatever the pin level.
// - reset sets every port data bit to one.
// - special off: select code maps straight to external input 0-7.
package adcr_pkg;

  // ----------------------------------------------------------------------
  // register map: offsets are word indices, byte address is index * 4
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_SPECIAL_CHANNEL_TEST = 6'h09;
  localparam logic [5:0] IDX_CONV_COMPLETE_STATUS = 6'h0B;
  localparam logic [5:0] IDX_DIGITAL_INPUT_ENABLE = 6'h0D;
  localparam logic [5:0] IDX_PIN_DIGITAL_READ = 6'h0F;
  localparam logic [5:0] IDX_FLAG_CTRL = 6'h10;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h11;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h12;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int SPECIAL_CHAN_EN_BIT = 0;
  localparam int FAST_FLAG_CLEAR_BIT = 0;
  localparam logic [7:0] TEST_READ_MASK = 8'h3F;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] INPUT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] PIN_READ_RESET = 8'hFF;
  localparam logic [7:0] PIN_READ_DISABLED = 8'hFF;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // converter input selection codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] SEL_HIGH_REF = 4'h8;
  localparam logic [3:0] SEL_LOW_REF = 4'h9;
  localparam logic [3:0] SEL_MID_REF = 4'hA;
  localparam logic [3:0] SEL_RESERVED = 4'hF;
  localparam logic [2:0] CODE_HIGH_REF = 3'h4;
  localparam logic [2:0] CODE_LOW_REF = 3'h5;
  localparam logic [2:0] CODE_MID_REF = 3'h6;

  typedef enum logic [2:0] {
    ADCR_REG_TEST,
    ADCR_REG_STATUS,
    ADCR_REG_ENABLE,
    ADCR_REG_PIN,
    ADCR_REG_CTRL,
    ADCR_REG_IRQ_STAT,
    ADCR_REG_IRQ_MASK,
    ADCR_REG_NONE
  } adcr_reg_t;

endpackage

/* logic/adcr_pin_if.sv */
// pin path signals shared between the register block and the pin sampler
`timescale 1ns/1ns
interface adcr_pin_if;
  logic [7:0] pin_level_bit;
  logic [7:0] input_buffer_on;
  logic [7:0] pin_digital_read;

  modport regs (
    output pin_level_bit,
    output input_buffer_on,
    input pin_digital_read
  );
  modport port (
    input pin_level_bit,
    input input_buffer_on,
    output pin_digital_read
  );
endinterface

/* logic/adcr_pin_sampler.sv */
// synchroniser and port data register for the shared analog pins
`timescale 1ns/1ns
module adcr_pin_sampler (
  input wire logic clk,
  input wire logic reset_n,
  adcr_pin_if.port pins
);

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] pin_read;
  } adcr_samp_t;

  adcr_samp_t s;
  adcr_samp_t next_s;

  localparam logic [7:0] PIN_MASK = adcr_pkg::PIN_READ_DISABLED;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // first stage feeds only the second; pins are asynchronous to clk
  always_comb begin
    next_s = s;
    next_s.sync1 = pins.pin_level_bit;
    next_s.sync2 = s.sync1;
    // disabled buffers read as one, enabled ones show the pin
    next_s.pin_read = (s.sync2 & pins.input_buffer_on) |
                      (PIN_MASK & ~pins.input_buffer_on);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '{sync1: 8'h00, sync2: 8'h00,
             pin_read: adcr_pkg::PIN_READ_RESET};
    end else begin
      s <= next_s;
    end
  end

  assign pins.pin_digital_read = s.pin_read;

endmodule

/* logic/adcr_status_test_port.sv */
// converter test, completion status, input enable and port data registers
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
module adcr_status_test_port (
  input wire logic clk,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sequencing engine side
  input wire logic conv_start_write,
  input wire logic [2:0] chan_sel,
  input wire logic conv_done,
  input wire logic [2:0] conv_done_index,
  input wire logic result_read,
  input wire logic [2:0] result_read_index,
  // analog mux and pins
  input wire logic [7:0] analog_pin,
  output logic [3:0] input_select,
  output logic select_reserved,
  output logic [7:0] input_buffer_on,
  output logic irq
);

  typedef struct packed {
    // write address and data channels
    logic aw_rdy;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_rdy;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    // write answer and read channel
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    // software-visible registers and flag bookkeeping
    logic [7:0] test_reg;
    logic [7:0] conv_done_flag;
    logic [7:0] status_armed;
    logic [7:0] digital_input_enable;
    logic fast_flag_clear;
    // interrupt and converter routing
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic irq;
    logic [3:0] input_select;
    logic select_reserved;
  } adcr_state_t;

  adcr_state_t s;
  adcr_state_t next_s;

  adcr_pin_if pin_bus ();

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // word-aligned decode; the two low address bits are ignored
  function automatic adcr_pkg::adcr_reg_t decode(input logic [7:0] addr);
    adcr_pkg::adcr_reg_t r;
    r = adcr_pkg::ADCR_REG_NONE;
    case (addr[7:2])
      adcr_pkg::IDX_SPECIAL_CHANNEL_TEST: r = adcr_pkg::ADCR_REG_TEST;
      adcr_pkg::IDX_CONV_COMPLETE_STATUS: r = adcr_pkg::ADCR_REG_STATUS;
      adcr_pkg::IDX_DIGITAL_INPUT_ENABLE: r = adcr_pkg::ADCR_REG_ENABLE;
      adcr_pkg::IDX_PIN_DIGITAL_READ: r = adcr_pkg::ADCR_REG_PIN;
      adcr_pkg::IDX_FLAG_CTRL: r = adcr_pkg::ADCR_REG_CTRL;
      adcr_pkg::IDX_IRQ_STATUS: r = adcr_pkg::ADCR_REG_IRQ_STAT;
      adcr_pkg::IDX_IRQ_MASK: r = adcr_pkg::ADCR_REG_IRQ_MASK;
      default: r = adcr_pkg::ADCR_REG_NONE;
    endcase
    return r;
  endfunction

  // one-hot of a three-bit index, used for done and result events
  function automatic logic [7:0] onehot(input logic fire,
                                        input logic [2:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (fire) begin
      v[idx] = 1'b1;
    end
    return v;
  endfunction

  // reset image of the whole state; readies open so a master may
  // start on the first edge after release
  function automatic adcr_state_t reset_state();
    adcr_state_t r;
    r = '0;
    r.aw_rdy = 1'b1;
    r.w_rdy = 1'b1;
    r.ar_rdy = 1'b1;
    r.test_reg = adcr_pkg::TEST_RESET;
    r.conv_done_flag = adcr_pkg::FLAGS_RESET;
    r.status_armed = adcr_pkg::FLAGS_RESET;
    r.digital_input_enable = adcr_pkg::INPUT_ENABLE_RESET;
    r.irq_status = adcr_pkg::FLAGS_RESET;
    r.irq_mask = adcr_pkg::IRQ_MASK_RESET;
    return r;
  endfunction

  // clear vector of the completion flags; a new sequence clears all
  function automatic logic [7:0] flag_clear(input logic fast,
                                            input logic [7:0] armed,
                                            input logic [7:0] rres,
                                            input logic start);
    logic [7:0] c;
    c = fast ? rres : (rres & armed);
    if (start) begin
      c = 8'hFF;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // pin path
  // ----------------------------------------------------------------------
  // pins go in raw; the sampler owns the synchroniser
  assign pin_bus.pin_level_bit = analog_pin;
  assign pin_bus.input_buffer_on = s.digital_input_enable;

  adcr_pin_sampler u_sampler (
    .clk(clk),
    .reset_n(reset_n),
    .pins(pin_bus)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    adcr_pkg::adcr_reg_t wsel;
    adcr_pkg::adcr_reg_t rsel;
    logic [7:0] done_vec;
    logic [7:0] rres_vec;
    logic [7:0] flag_clr;
    logic [7:0] irq_clr;
    logic status_read;
    logic do_write;
    // decode both addresses and turn events into vectors
    wsel = decode(s.aw_addr);
    rsel = decode(s_axi_araddr);
    done_vec = onehot(conv_done, conv_done_index);
    rres_vec = onehot(result_read, result_read_index);
    flag_clr = 8'h00;
    irq_clr = 8'h00;
    status_read = 1'b0;
    do_write = s.aw_held && s.w_held && !s.bvalid;
    next_s = s;

    // address and data are taken independently, in either order
    if (s.aw_rdy && s_axi_awvalid) begin
      next_s.aw_rdy = 1'b0;
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.w_rdy && s_axi_wvalid) begin
      next_s.w_rdy = 1'b0;
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata[7:0];
      next_s.w_lane0 = s_axi_wstrb[0];
    end

    // write commits once both halves are held; only lane 0 carries data
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = adcr_pkg::RESP_OKAY;
      case (wsel)
        adcr_pkg::ADCR_REG_TEST: begin
          // all bits stored; only the enable bit steers the mux
          if (s.w_lane0) begin
            next_s.test_reg = s.w_data;
          end
        end
        // input enable register drives the buffers directly
        adcr_pkg::ADCR_REG_ENABLE: begin
          if (s.w_lane0) begin
            next_s.digital_input_enable = s.w_data;
          end
        end
        // own control register, fast flag clear option
        adcr_pkg::ADCR_REG_CTRL: begin
          if (s.w_lane0) begin
            next_s.fast_flag_clear = s.w_data[adcr_pkg::FAST_FLAG_CLEAR_BIT];
          end
        end
        // interrupt status is write one to clear
        adcr_pkg::ADCR_REG_IRQ_STAT: begin
          if (s.w_lane0) begin
            irq_clr = s.w_data;
          end
        end
        // mask has the layout of the interrupt status
        adcr_pkg::ADCR_REG_IRQ_MASK: begin
          if (s.w_lane0) begin
            next_s.irq_mask = s.w_data;
          end
        end
        // read-only registers accept the write and keep their value
        adcr_pkg::ADCR_REG_STATUS:
          next_s.bresp = adcr_pkg::RESP_OKAY;
        adcr_pkg::ADCR_REG_PIN: next_s.bresp = adcr_pkg::RESP_OKAY;
        default: next_s.bresp = adcr_pkg::RESP_SLVERR;
      endcase
    end

    // response taken: open both write channels again
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
      next_s.aw_rdy = 1'b1;
      next_s.w_rdy = 1'b1;
    end

    // read: data answered one cycle after the address is taken
    if (s.ar_rdy && s_axi_arvalid) begin
      next_s.ar_rdy = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = adcr_pkg::RESP_OKAY;
      case (rsel)
        adcr_pkg::ADCR_REG_TEST:
          next_s.rdata = s.test_reg & adcr_pkg::TEST_READ_MASK;
        // a status read arms the flags it returns
        adcr_pkg::ADCR_REG_STATUS: begin
          next_s.rdata = s.conv_done_flag;
          status_read = 1'b1;
        end
        adcr_pkg::ADCR_REG_ENABLE:
          next_s.rdata = s.digital_input_enable;
        // pin data trails the pins by three edges
        adcr_pkg::ADCR_REG_PIN:
          next_s.rdata = pin_bus.pin_digital_read;
        adcr_pkg::ADCR_REG_CTRL:
          next_s.rdata = {7'h00, s.fast_flag_clear};
        adcr_pkg::ADCR_REG_IRQ_STAT:
          next_s.rdata = s.irq_status;
        adcr_pkg::ADCR_REG_IRQ_MASK:
          next_s.rdata = s.irq_mask;
        default: begin
          next_s.rdata = 8'h00;
          next_s.rresp = adcr_pkg::RESP_SLVERR;
        end
      endcase
    end
    // read answer taken: accept the next address
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
      next_s.ar_rdy = 1'b1;
    end

    // flag clearing: a status read arms the flags then set
    flag_clr = flag_clear(s.fast_flag_clear, s.status_armed, rres_vec,
                          conv_start_write);
    // arming: a result read disarms its flag, a start disarms all
    next_s.status_armed = s.status_armed & ~rres_vec;
    if (status_read) begin
      next_s.status_armed = next_s.status_armed | s.conv_done_flag;
    end
    if (conv_start_write) begin
      next_s.status_armed = 8'h00;
    end
    // a completion in the clearing cycle survives the clear
    next_s.conv_done_flag = (s.conv_done_flag & ~flag_clr) |
                            done_vec;

    // interrupt: sticky, write one to clear, set beats clear
    next_s.irq_status = (s.irq_status & ~irq_clr) | done_vec;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);

    // converter input routing from select code
    next_s.select_reserved = 1'b0;
    if (s.test_reg[adcr_pkg::SPECIAL_CHAN_EN_BIT]) begin
      case (chan_sel)
        adcr_pkg::CODE_HIGH_REF:
          next_s.input_select = adcr_pkg::SEL_HIGH_REF;
        adcr_pkg::CODE_LOW_REF:
          next_s.input_select = adcr_pkg::SEL_LOW_REF;
        adcr_pkg::CODE_MID_REF:
          next_s.input_select = adcr_pkg::SEL_MID_REF;
        default: begin
          // reserved codes connect nothing rather than a stray pin
          next_s.input_select = adcr_pkg::SEL_RESERVED;
          next_s.select_reserved = 1'b1;
        end
      endcase
    end else begin
      // plain mode: the code is the external pin number
      next_s.input_select = {1'b0, chan_sel};
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  // synchronous reset loads the whole reset image in one step
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= reset_state();
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  // bus side
  assign s_axi_awready = s.aw_rdy;
  assign s_axi_wready = s.w_rdy;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.ar_rdy;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = {24'h000000, s.rdata};
  assign s_axi_rresp = s.rresp;

  // converter side
  assign input_select = s.input_select;
  assign select_reserved = s.select_reserved;
  assign input_buffer_on = s.digital_input_enable;
  assign irq = s.irq;

endmodule

/* testbench/adcr_stp_props.sv */
// port-level assertions for the converter register block
`timescale 1ns/1ns
module adcr_stp_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] chan_sel,
  input wire logic [3:0] input_select,
  input wire logic select_reserved,
  input wire logic [7:0] input_buffer_on,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ------
  // converter input selection, one edge behind the code
  // ------
  AST_SEL_EXT: assert property (
    $past(reset_n) && !input_select[3] |->
    input_select[2:0] == $past(chan_sel)) else $error("direct select wrong");
  AST_SEL_SPC: assert property (
    input_select inside {4'h8, 4'h9, 4'hA} |->
    $past(chan_sel) == {1'b1, input_select[1:0]}) else $error("special wrong");
  AST_SEL_RSV: assert property (
    select_reserved |-> input_select == 4'hF &&
    (!$past(chan_sel[2]) || $past(chan_sel) == 3'h7)) else $error("reserved");
  // ------
  // bus handshakes; answers must stand until taken
  // ------
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_AR_R: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  AST_W_B: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
    ##[1:2] s_axi_bvalid) else $error("write not answered");
  // enables move only while a write is in flight
  AST_BUF_WR: assert property (
    $changed(input_buffer_on) |-> !s_axi_wready)
    else $error("enable changed without write");
  AST_RST_VAL: assert property (
    $rose(reset_n) |-> !irq && input_buffer_on == 8'h00)
    else $error("bad reset state");
  C_RSV: cover property (select_reserved);
  C_HIGH: cover property (input_select == 4'h8);
  C_IRQ: cover property (irq);
endmodule

bind adcr_status_test_port adcr_stp_props i_adcr_stp_props (
  .clk(clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .chan_sel(chan_sel),
  .input_select(input_select), .select_reserved(select_reserved),
  .input_buffer_on(input_buffer_on), .irq(irq)
);

/* testbench/test_adc_status_test_port_regs.sv */
// self-checking bench for the converter register block
`timescale 1ns/1ns
module test_adc_status_test_port_regs;
  localparam logic [7:0] A_TST = {adcr_pkg::IDX_SPECIAL_CHANNEL_TEST, 2'h0};
  localparam logic [7:0] A_STS = {adcr_pkg::IDX_CONV_COMPLETE_STATUS, 2'h0};
  localparam logic [7:0] A_IEN = {adcr_pkg::IDX_DIGITAL_INPUT_ENABLE, 2'h0};
  localparam logic [7:0] A_PIN = {adcr_pkg::IDX_PIN_DIGITAL_READ, 2'h0};
  localparam logic [7:0] A_CTL = {adcr_pkg::IDX_FLAG_CTRL, 2'h0};
  localparam logic [7:0] A_IST = {adcr_pkg::IDX_IRQ_STATUS, 2'h0};
  localparam logic [7:0] A_IMK = {adcr_pkg::IDX_IRQ_MASK, 2'h0};
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic cstart, cdone, rrd, awready, wready, bvalid, arready, rvalid;
  logic sres, irq;
  logic [7:0] awaddr, araddr, pins, ben;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] wstrb, isel;
  logic [2:0] csel, didx, ridx;
  logic [1:0] bresp, rresp, rsp;
  int err_total = 0;
  int n_checks = 0;
  // ------
  // device and clock
  // ------
  adcr_status_test_port i_adcr_status_test_port (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .conv_start_write(cstart), .chan_sel(csel),
    .conv_done(cdone), .conv_done_index(didx), .result_read(rrd),
    .result_read_index(ridx), .analog_pin(pins), .input_select(isel),
    .select_reserved(sres), .input_buffer_on(ben), .irq(irq)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ------
  // shared tasks
  // ------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int t;
    logic ad, dd;
    t = 0;
    ad = 0;
    dd = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (t < 50) begin
      @(posedge clk);
      t++;
      if (ad && dd && bvalid) t = 99;
      if (awready) ad = 1;
      if (wready) dd = 1;
      if (ad) awvalid <= 1'b0;
      if (dd) wvalid <= 1'b0;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (t != 99) chk(32'h0, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a);
    int t;
    logic ad;
    t = 0;
    ad = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (t < 50) begin
      @(posedge clk);
      t++;
      if (ad && rvalid) t = 99;
      if (arready) ad = 1;
      if (ad) arvalid <= 1'b0;
    end
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (t != 99) chk(32'h0, 32'h1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rdv, {24'h0, e});
  endtask
  // one-cycle pulse: 0 conversion done, 1 result read, 2 start
  task automatic ev(input int k, input logic [2:0] i);
    @(posedge clk);
    cdone <= (k == 0);
    rrd <= (k == 1);
    cstart <= (k == 2);
    didx <= i;
    ridx <= i;
    @(posedge clk);
    cdone <= 1'b0;
    rrd <= 1'b0;
    cstart <= 1'b0;
    @(posedge clk);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_reset;
    rdc(A_TST, 8'h00);
    rdc(A_STS, 8'h00);
    rdc(A_PIN, 8'hFF);
    $display("reset values done");
  endtask
  task automatic t_select;
    logic [3:0] e;
    for (int s = 0; s < 2; s++) begin
      wr(A_TST, 8'(s));
      rdc(A_TST, 8'(s));
      for (int c = 0; c < 8; c++) begin
        @(posedge clk);
        csel <= 3'(c);
        repeat (2) @(posedge clk);
        e = (s == 0) ? 4'(c) : (c > 3 && c < 7) ? 4'(c + 4) : 4'hF;
        chk(isel, e);
        chk(sres, s == 1 && e == 4'hF);
      end
    end
    wr(A_TST, 8'h00);
    $display("select codes done");
  endtask
  task automatic t_flags;
    ev(2, 3'h0);
    for (int i = 0; i < 8; i++) ev(0, 3'(i));
    ev(1, 3'h3);
    rdc(A_STS, 8'hFF);
    ev(1, 3'h3);
    rdc(A_STS, 8'hF7);
    wr(A_CTL, 8'h01);
    ev(1, 3'h5);
    rdc(A_STS, 8'hD7);
    wr(A_STS, 8'hFF);
    chk(rsp, 2'h0);
    rdc(A_STS, 8'hD7);
    ev(2, 3'h0);
    rdc(A_STS, 8'h00);
    wr(A_CTL, 8'h00);
    $display("completion flags done");
  endtask
  task automatic t_irq;
    wr(A_IMK, 8'h00);
    wr(A_IST, 8'hFF);
    ev(0, 3'h2);
    rdc(A_IST, 8'h04);
    chk(irq, 1'b0);
    wr(A_IMK, 8'h04);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(A_IST, 8'h04);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rdc(A_IST, 8'h00);
    $display("interrupt done");
  endtask
  task automatic t_pins;
    wr(A_IEN, 8'hA5);
    rdc(A_IEN, 8'hA5);
    chk(ben, 8'hA5);
    wstrb <= 4'h0;
    wr(A_IEN, 8'h00);
    rdc(A_IEN, 8'hA5);
    wstrb <= 4'h1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pins <= k ? 8'hC3 : 8'h3C;
      repeat (4) @(posedge clk);
      rdc(A_PIN, (pins & 8'hA5) | 8'h5A);
    end
    wr(A_PIN, 8'h00);
    rdc(A_PIN, 8'hDB);
    rd(8'h50);
    chk(rsp, 2'h2);
    chk(rdv, 32'h0);
    wr(8'h50, 8'h11);
    chk(rsp, 2'h2);
    $display("pin read done");
  endtask
  // second reset mid-run: enables and pin reads go back to reset values
  task automatic t_rerun;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(ben, 8'h00);
    chk(irq, 1'b0);
    rdc(A_PIN, 8'hFF);
    rdc(A_IEN, 8'h00);
    $display("mid-run reset done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    results;
  end
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {cstart, cdone, rrd, csel, didx, ridx} = 12'h0;
    {awaddr, araddr, wdata, pins} = 56'h0;
    wstrb = 4'h1;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_select;
    t_flags;
    t_irq;
    t_pins;
    t_rerun;
    results;
  end
endmodule
